// [perf_mon_pkg.sv]
`default_nettype none
package perf_mon_pkg;

  // Second categories, window, 15-minute, day and month counts and one alarm each
  localparam int NCAT                   = 12;
  localparam int CAT_ERRORED_SECOND     = 0;
  localparam int CAT_BURSTY_ERROR       = 1;
  localparam int CAT_SEVERE_ERROR       = 2;
  localparam int CAT_UNAVAILABLE        = 3;
  localparam int CAT_CONTROLLED_SLIP    = 4;
  localparam int CAT_CRC_ERRORED        = 5;
  localparam int CAT_FRAMING_LOSS       = 6;
  localparam int CAT_SIGNAL_LOSS        = 7;
  localparam int CAT_ALARM_INDICATION   = 8;
  localparam int CAT_REMOTE_ALARM       = 9;
  localparam int CAT_BIPOLAR_VIOLATION  = 10;
  localparam int CAT_FRAME_LOSS_DECL    = 11;

  // Count widths
  localparam int BIN_W = 6;
  localparam int WIN_W = 10;
  localparam int DAY_W = 17;
  localparam int MON_W = 22;
  localparam int CRC_W = 9;
  localparam int RUN_W = 4;

  // Time structure
  localparam int BINS        = 15;
  localparam int SEC_PER_MIN = 60;
  localparam int MIN_PER_Q   = 15;
  localparam int Q_PER_DAY   = 96;
  localparam int DAYS        = 30;

  // Classification limits
  localparam logic [CRC_W-1:0] CRC_SEVERE    = 9'h140;
  localparam logic [CRC_W-1:0] CRC_BURST_MIN = 9'h002;
  localparam logic [CRC_W-1:0] CRC_ONE       = 9'h001;
  localparam logic [RUN_W-1:0] UAS_RUN       = 4'hA;

  // Timing
  localparam int CLK_HZ      = 25_000_000;
  localparam int HALF_MS     = 500;
  localparam int LOF_TIME_MS = 2500;
  localparam logic [2:0] LOF_HALVES = 3'(LOF_TIME_MS / HALF_MS);

  // Threshold and reset timer
  localparam logic [WIN_W-1:0] THR_MAX       = 10'h384;
  localparam logic [WIN_W-1:0] RTIMER_RESET  = 10'h01E;
  localparam logic [NCAT-1:0][WIN_W-1:0] THR_RESET = {
    10'h000, 10'h000, 10'h000, 10'h000, 10'h005, 10'h005,
    10'h000, 10'h000, 10'h000, 10'h005, 10'h000, 10'h02D};

  // Register map: group in addr[7:4], category in addr[3:0]
  localparam logic [3:0] GRP_THR    = 4'h0;
  localparam logic [3:0] GRP_WIN    = 4'h1;
  localparam logic [3:0] GRP_CUR15  = 4'h2;
  localparam logic [3:0] GRP_DAY    = 4'h3;
  localparam logic [3:0] GRP_MONTH  = 4'h4;
  localparam logic [3:0] GRP_MISC   = 4'h5;
  localparam logic [3:0] IDX_RTIMER = 4'h0;
  localparam logic [3:0] IDX_CTRL   = 4'h1;
  localparam logic [3:0] IDX_ALARM  = 4'h2;
  localparam logic [3:0] IDX_AVAIL  = 4'h3;
  localparam int         CTRL_CLEAR = 0;

  // Per-clock line indications
  typedef struct packed {
    logic logic_err;
    logic crc_err;
    logic out_of_frame_event;
    logic signal_loss;
    logic slip;
    logic bipolar_violation;
    logic all_ones;
    logic remote_alarm;
  } line_ev_s;

  typedef enum logic [0:0] {
    AVAILABLE   = 1'b0,
    UNAVAILABLE = 1'b1
  } avail_e;

endpackage : perf_mon_pkg
`default_nettype wire

// [stat_mem.sv]
`default_nettype none
module stat_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock
  input  wire logic             clk,
  // Write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // Read port
  input  wire logic [AW-1:0]    raddr,
  output var  logic [WIDTH-1:0] rdata_q
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end

endmodule : stat_mem
`default_nettype wire

// [sec_tick.sv]
`default_nettype none
module sec_tick #(
  parameter int TICKS_PER_SEC = 25_000_000
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic srst,
  // Enables
  output var  logic half_q,
  output var  logic sec_q
);

  localparam int HALF = TICKS_PER_SEC / 2;
  localparam int CW   = $clog2(HALF + 1);
  localparam logic [CW-1:0] LAST = CW'(HALF - 1);

  logic [CW-1:0] cnt_q, cnt_d;
  logic          phase_q, phase_d;
  logic          half_d, sec_d;

  always_comb begin
    half_d  = (cnt_q == LAST);
    sec_d   = half_d & phase_q;
    cnt_d   = half_d ? '0 : CW'(cnt_q + 1'b1);
    phase_d = half_d ? ~phase_q : phase_q;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
      half_q  <= 1'b0;
      sec_q   <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
      half_q  <= half_d;
      sec_q   <= sec_d;
    end
  end

endmodule : sec_tick
`default_nettype wire

// [line_error_perf_monitor.sv]
// The address-and-strobe port and the register addresses were chosen for this implementation.
`default_nettype none
module line_error_perf_monitor
  import perf_mon_pkg::*;
#(
  parameter int TICKS_PER_SEC = CLK_HZ
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            srst,
  // Line indications
  input  wire line_ev_s        line_ev,
  // Register port
  input  wire logic [7:0]      addr,
  input  wire logic [31:0]     wdata,
  input  wire logic            we,
  input  wire logic            re,
  output var  logic [31:0]     rdata_q,
  // Status
  output var  logic [NCAT-1:0] alarm_q,
  output var  logic            unavailable_q
);

  ////////////////////////////////////////////////////////////////////////
  // Timebase

  logic half_p, sec_p;

  sec_tick #(
    .TICKS_PER_SEC (TICKS_PER_SEC)
  ) u_tick (
    .clk    (clk),
    .srst   (srst),
    .half_q (half_p),
    .sec_q  (sec_p)
  );

  ////////////////////////////////////////////////////////////////////////
  // State

  line_ev_s                     seen_q, seen_d, seen_now;
  logic [CRC_W-1:0]             crc_q, crc_d, crc_now;
  logic                         lof_hold_q, lof_hold_d, hold_now;
  logic [2:0]                   lof_run_q, lof_run_d;
  logic                         lof_seen_q, lof_seen_d, lof_decl;
  logic [RUN_W-1:0]             ses_run_q, ses_run_d;
  logic [RUN_W-1:0]             ok_run_q, ok_run_d;
  avail_e                       avail_q, avail_d;
  logic [5:0]                   sec_cnt_q, sec_cnt_d;
  logic [3:0]                   min_cnt_q, min_cnt_d;
  logic [6:0]                   q_ptr_q, q_ptr_d;
  logic [4:0]                   d_ptr_q, d_ptr_d;
  logic [3:0]                   bin_fill_q, bin_fill_d;
  logic                         q_full_q, q_full_d;
  logic                         d_full_q, d_full_d;
  logic [NCAT-1:0][BIN_W-1:0]   cur_min_q, cur_min_d;
  logic [NCAT-1:0][WIN_W-1:0]   win_q, win_d;
  logic [NCAT-1:0][WIN_W-1:0]   cur15_q, cur15_d;
  logic [NCAT-1:0][DAY_W-1:0]   sum24_q, sum24_d;
  logic [NCAT-1:0][DAY_W-1:0]   day_q, day_d;
  logic [NCAT-1:0][MON_W-1:0]   sum30_q, sum30_d;
  logic [NCAT-1:0][WIN_W-1:0]   run_q, run_d;
  logic [NCAT-1:0]              alarm_d;
  logic [NCAT-1:0][WIN_W-1:0]   thr_q, thr_d;
  logic [WIN_W-1:0]             rtimer_q, rtimer_d;
  logic [31:0]                  rdata_d;

  logic [NCAT-1:0]              cat;
  logic                         severe_error_second;
  logic                         min_p, q_p, d_p, clear_cmd;
  logic [NCAT-1:0][BIN_W-1:0]   bin_wr, bin_rd;
  logic [NCAT-1:0][WIN_W-1:0]   q_wr, q_rd;
  logic [NCAT-1:0][DAY_W-1:0]   d_wr, d_rd;
  logic [BIN_W-1:0]             mt;
  logic [WIN_W-1:0]             qt;
  logic [DAY_W-1:0]             dt;

  ////////////////////////////////////////////////////////////////////////
  // History memories

  stat_mem #(.WIDTH (NCAT*BIN_W), .DEPTH (BINS)) u_bins (
    .clk     (clk),
    .we      (min_p),
    .waddr   (min_cnt_q),
    .wdata   (bin_wr),
    .raddr   (min_cnt_q),
    .rdata_q (bin_rd)
  );

  stat_mem #(.WIDTH (NCAT*WIN_W), .DEPTH (Q_PER_DAY)) u_quarters (
    .clk     (clk),
    .we      (q_p),
    .waddr   (q_ptr_q),
    .wdata   (q_wr),
    .raddr   (q_ptr_q),
    .rdata_q (q_rd)
  );

  stat_mem #(.WIDTH (NCAT*DAY_W), .DEPTH (DAYS)) u_days (
    .clk     (clk),
    .we      (d_p),
    .waddr   (d_ptr_q),
    .wdata   (d_wr),
    .raddr   (d_ptr_q),
    .rdata_q (d_rd)
  );

  ////////////////////////////////////////////////////////////////////////
  // Per-second classification and counting

  always_comb begin
    clear_cmd = we && addr == {GRP_MISC, IDX_CTRL} && wdata[CTRL_CLEAR];
    min_p = sec_p && sec_cnt_q == 6'(SEC_PER_MIN - 1);
    q_p   = min_p && min_cnt_q == 4'(MIN_PER_Q - 1);
    d_p   = q_p && q_ptr_q == 7'(Q_PER_DAY - 1);

    // Accumulate within the second, levels and pulses alike
    seen_now = seen_q | line_ev;
    crc_now  = crc_q;
    if (line_ev.crc_err && crc_q != CRC_SEVERE) begin
      crc_now = CRC_W'(crc_q + 1'b1);
    end

    // Loss-of-frame declaration on 2.5 s of continuous loss or OUT_OF_FRAME_EVENT
    hold_now  = lof_hold_q
              & (line_ev.signal_loss | line_ev.out_of_frame_event);
    lof_decl  = 1'b0;
    lof_hold_d = hold_now;
    lof_run_d  = lof_run_q;
    if (half_p) begin
      lof_hold_d = 1'b1;
      if (!hold_now) begin
        lof_run_d = '0;
      end else if (lof_run_q != LOF_HALVES) begin
        lof_run_d = 3'(lof_run_q + 1'b1);
        lof_decl  = (lof_run_q == 3'(LOF_HALVES - 1));
      end
    end
    lof_seen_d = lof_seen_q | lof_decl;

    severe_error_second = (crc_now >= CRC_SEVERE) | seen_now.out_of_frame_event;

    // Unavailable state on runs of severe seconds
    ses_run_d = ses_run_q;
    ok_run_d  = ok_run_q;
    avail_d   = avail_q;
    if (sec_p) begin
      ses_run_d = severe_error_second ? ((ses_run_q == UAS_RUN) ? ses_run_q
                         : RUN_W'(ses_run_q + 1'b1)) : '0;
      ok_run_d  = !severe_error_second ? ((ok_run_q == UAS_RUN) ? ok_run_q
                          : RUN_W'(ok_run_q + 1'b1)) : '0;
      case (avail_q)
        AVAILABLE: begin
          if (severe_error_second && ses_run_q == RUN_W'(UAS_RUN - 1'b1)) begin
            avail_d = UNAVAILABLE;
          end
        end
        UNAVAILABLE: begin
          if (!severe_error_second && ok_run_q == RUN_W'(UAS_RUN - 1'b1)) begin
            avail_d = AVAILABLE;
          end
        end
        default: avail_d = AVAILABLE;
      endcase
    end

    cat = '0;
    cat[CAT_ERRORED_SECOND]    = seen_now.logic_err;
    cat[CAT_BURSTY_ERROR]      = crc_now >= CRC_BURST_MIN
                               && crc_now < CRC_SEVERE;
    cat[CAT_SEVERE_ERROR]      = severe_error_second;
    cat[CAT_UNAVAILABLE]       = avail_d == UNAVAILABLE;
    cat[CAT_CONTROLLED_SLIP]   = seen_now.slip;
    cat[CAT_CRC_ERRORED]       = crc_now >= CRC_ONE;
    cat[CAT_FRAMING_LOSS]      = seen_now.out_of_frame_event;
    cat[CAT_SIGNAL_LOSS]       = seen_now.signal_loss;
    cat[CAT_ALARM_INDICATION]  = seen_now.all_ones;
    cat[CAT_REMOTE_ALARM]      = seen_now.remote_alarm;
    cat[CAT_BIPOLAR_VIOLATION] = seen_now.bipolar_violation;
    cat[CAT_FRAME_LOSS_DECL]   = lof_seen_d;

    seen_d = sec_p ? '0 : seen_now;
    crc_d  = sec_p ? '0 : crc_now;
    if (sec_p) begin
      lof_seen_d = 1'b0;
    end

    // Time counters
    sec_cnt_d  = sec_cnt_q;
    min_cnt_d  = min_cnt_q;
    q_ptr_d    = q_ptr_q;
    d_ptr_d    = d_ptr_q;
    bin_fill_d = bin_fill_q;
    q_full_d   = q_full_q | d_p;
    d_full_d   = d_full_q | (d_p && d_ptr_q == 5'(DAYS - 1));
    if (sec_p) begin
      sec_cnt_d = min_p ? '0 : 6'(sec_cnt_q + 1'b1);
    end
    if (min_p) begin
      min_cnt_d = q_p ? '0 : 4'(min_cnt_q + 1'b1);
      if (bin_fill_q != 4'(BINS)) begin
        bin_fill_d = 4'(bin_fill_q + 1'b1);
      end
    end
    if (q_p) begin
      q_ptr_d = d_p ? '0 : 7'(q_ptr_q + 1'b1);
    end
    if (d_p) begin
      d_ptr_d = (d_ptr_q == 5'(DAYS - 1)) ? '0 : 5'(d_ptr_q + 1'b1);
    end

    // Per-category counts, window and alarm
    cur_min_d = cur_min_q;
    win_d     = win_q;
    cur15_d   = cur15_q;
    sum24_d   = sum24_q;
    day_d     = day_q;
    sum30_d   = sum30_q;
    run_d     = run_q;
    alarm_d   = alarm_q;
    bin_wr    = '0;
    q_wr      = '0;
    d_wr      = '0;
    mt        = '0;
    qt        = '0;
    dt        = '0;
    for (int i = 0; i < NCAT; i++) begin
      mt = BIN_W'(cur_min_q[i] + cat[i]);
      qt = WIN_W'(cur15_q[i] + cat[i]);
      dt = DAY_W'(day_q[i] + qt);
      bin_wr[i] = mt;
      q_wr[i]   = qt;
      d_wr[i]   = dt;
      if (sec_p) begin
        cur_min_d[i] = mt;
        cur15_d[i]   = qt;
        run_d[i]     = cat[i] ? '0 : ((run_q[i] == THR_MAX) ? run_q[i]
                                      : WIN_W'(run_q[i] + 1'b1));
      end
      if (min_p) begin
        cur_min_d[i] = '0;
        win_d[i] = WIN_W'(win_q[i] + mt - ((bin_fill_q == 4'(BINS))
                                ? WIN_W'(bin_rd[i]) : '0));
      end
      if (q_p) begin
        cur15_d[i] = '0;
        day_d[i]   = dt;
        sum24_d[i] = DAY_W'(sum24_q[i] + qt
                     - (q_full_q ? DAY_W'(q_rd[i]) : '0));
      end
      if (d_p) begin
        day_d[i]   = '0;
        sum30_d[i] = MON_W'(sum30_q[i] + dt
                     - (d_full_q ? MON_W'(d_rd[i]) : '0));
      end
      if (sec_p) begin
        if (alarm_q[i] && rtimer_q != '0 && run_d[i] >= rtimer_q) begin
          alarm_d[i] = 1'b0;
        end
        if (thr_q[i] != '0 && win_d[i] >= thr_q[i]) begin
          alarm_d[i] = 1'b1;
        end
      end
    end

    if (clear_cmd) begin
      alarm_d    = '0;
      win_d      = '0;
      cur_min_d  = '0;
      cur15_d    = '0;
      run_d      = '0;
      bin_fill_d = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      seen_q        <= '0;
      crc_q         <= '0;
      lof_hold_q    <= 1'b1;
      lof_run_q     <= '0;
      lof_seen_q    <= 1'b0;
      ses_run_q     <= '0;
      ok_run_q      <= '0;
      avail_q       <= AVAILABLE;
      sec_cnt_q     <= '0;
      min_cnt_q     <= '0;
      q_ptr_q       <= '0;
      d_ptr_q       <= '0;
      bin_fill_q    <= '0;
      q_full_q      <= 1'b0;
      d_full_q      <= 1'b0;
      cur_min_q     <= '0;
      win_q         <= '0;
      cur15_q       <= '0;
      sum24_q       <= '0;
      day_q         <= '0;
      sum30_q       <= '0;
      run_q         <= '0;
      alarm_q       <= '0;
      unavailable_q <= 1'b0;
    end else begin
      seen_q        <= seen_d;
      crc_q         <= crc_d;
      lof_hold_q    <= lof_hold_d;
      lof_run_q     <= lof_run_d;
      lof_seen_q    <= lof_seen_d;
      ses_run_q     <= ses_run_d;
      ok_run_q      <= ok_run_d;
      avail_q       <= avail_d;
      sec_cnt_q     <= sec_cnt_d;
      min_cnt_q     <= min_cnt_d;
      q_ptr_q       <= q_ptr_d;
      d_ptr_q       <= d_ptr_d;
      bin_fill_q    <= bin_fill_d;
      q_full_q      <= q_full_d;
      d_full_q      <= d_full_d;
      cur_min_q     <= cur_min_d;
      win_q         <= win_d;
      cur15_q       <= cur15_d;
      sum24_q       <= sum24_d;
      day_q         <= day_d;
      sum30_q       <= sum30_d;
      run_q         <= run_d;
      alarm_q       <= alarm_d;
      unavailable_q <= (avail_d == UNAVAILABLE);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register port

  always_comb begin
    thr_d    = thr_q;
    rtimer_d = rtimer_q;
    rdata_d  = '0;
    if (we && addr[7:4] == GRP_THR && addr[3:0] < 4'(NCAT)) begin
      thr_d[addr[3:0]] = (wdata > 32'(THR_MAX)) ? THR_MAX
                         : wdata[WIN_W-1:0];
    end
    if (we && addr == {GRP_MISC, IDX_RTIMER}) begin
      rtimer_d = (wdata > 32'(THR_MAX)) ? THR_MAX
                 : wdata[WIN_W-1:0];
    end
    if (re) begin
      if (addr[3:0] < 4'(NCAT)) begin
        case (addr[7:4])
          GRP_THR:   rdata_d = 32'(thr_q[addr[3:0]]);
          GRP_WIN:   rdata_d = 32'(win_q[addr[3:0]]);
          GRP_CUR15: rdata_d = 32'(cur15_q[addr[3:0]]);
          GRP_DAY:   rdata_d = 32'(sum24_q[addr[3:0]]);
          GRP_MONTH: rdata_d = 32'(sum30_q[addr[3:0]]);
          default:   rdata_d = '0;
        endcase
      end
      if (addr[7:4] == GRP_MISC) begin
        case (addr[3:0])
          IDX_RTIMER: rdata_d = 32'(rtimer_q);
          IDX_ALARM:  rdata_d = 32'(alarm_q);
          IDX_AVAIL:  rdata_d = 32'(avail_q);
          default:    rdata_d = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      thr_q    <= THR_RESET;
      rtimer_q <= RTIMER_RESET;
      rdata_q  <= '0;
    end else begin
      thr_q    <= thr_d;
      rtimer_q <= rtimer_d;
      rdata_q  <= rdata_d;
    end
  end

endmodule : line_error_perf_monitor
`default_nettype wire

// [perf_mon_properties.sv]
`default_nettype none
module perf_mon_checker
  import perf_mon_pkg::*;
#(
  parameter int TICKS_PER_SEC = CLK_HZ
) (
  // Clock and reset
  input wire logic            clk,
  input wire logic            srst,
  // Line and register inputs
  input wire line_ev_s        line_ev,
  input wire logic [7:0]      addr,
  input wire logic [31:0]     wdata,
  input wire logic            we,
  input wire logic            re,
  // Outputs
  input wire logic [31:0]     rdata_q,
  input wire logic [NCAT-1:0] alarm_q,
  input wire logic            unavailable_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence thr_write;
    we && addr[7:4] == GRP_THR && addr[3:0] < 4'hC;
  endsequence
  sequence thr_read;
    re && addr == $past(addr);
  endsequence

  a_reset_outputs: assert property (disable iff (1'b0)
    srst |=> rdata_q == 32'h0 && alarm_q == '0 && !unavailable_q)
    else $error("outputs not cleared by reset");
  a_idle_read_zero: assert property (!re |=> rdata_q == 32'h0)
    else $error("read data not zero outside a read");
  a_thr_readback: assert property (thr_write ##1 thr_read |=>
    rdata_q == ($past(wdata, 2) > 32'h384 ? 32'h384 : $past(wdata, 2)))
    else $error("threshold read back wrong");
  a_thr_capped: assert property (
    re && addr[7:4] == GRP_THR |=> rdata_q <= 32'h384)
    else $error("threshold above limit");
  a_unmapped_zero: assert property (re && addr[7:4] > GRP_MISC |=>
    rdata_q == 32'h0) else $error("unmapped read not zero");
  a_bad_index: assert property (re && addr[7:4] < GRP_MISC &&
    addr[3:0] >= 4'hC |=> rdata_q == 32'h0)
    else $error("bad category index read not zero");
  a_ctrl_reads: assert property (re && addr == {GRP_MISC, IDX_CTRL} |=>
    rdata_q == 32'h0) else $error("control read not zero");
  a_alarm_read: assert property (re && addr == {GRP_MISC, IDX_ALARM}
    |=> rdata_q == {20'h0, $past(alarm_q)})
    else $error("alarm register differs from alarm port");
  a_avail_read: assert property (re && addr == {GRP_MISC, IDX_AVAIL}
    |=> rdata_q == {31'h0, $past(unavailable_q)})
    else $error("state register differs from port");
  a_clear_drops: assert property (we && addr == {GRP_MISC, IDX_CTRL}
    && wdata[CTRL_CLEAR] |=> alarm_q == '0)
    else $error("alarms not dropped by clear");
endmodule : perf_mon_checker

bind line_error_perf_monitor perf_mon_checker #(
  .TICKS_PER_SEC(TICKS_PER_SEC)
) u_chk (.clk(clk), .srst(srst), .line_ev(line_ev), .addr(addr),
  .wdata(wdata), .we(we), .re(re), .rdata_q(rdata_q),
  .alarm_q(alarm_q), .unavailable_q(unavailable_q));
`default_nettype wire

// [line_framer_model.sv]
`default_nettype none
module line_framer_model
  import perf_mon_pkg::*;
(
  // Clock
  input  wire logic clk,
  // Indications toward the monitor
  output var  line_ev_s line_ev
);
  timeunit 1ns;
  timeprecision 1ps;
  line_ev_s hold_q = '0;
  initial line_ev = '0;

  // Raise events for n clocks, levels kept underneath
  task automatic pulse(input line_ev_s ev, input int n);
    line_ev <= hold_q | ev;
    repeat (n) @(posedge clk);
    line_ev <= hold_q;
  endtask : pulse

  // Steady conditions such as loss of frame
  task automatic set_hold(input line_ev_s ev);
    hold_q = ev;
    line_ev <= ev;
  endtask : set_hold
endmodule : line_framer_model
`default_nettype wire

// [line_error_perf_monitor_test.sv]
`default_nettype none
module line_error_perf_monitor_test
  import perf_mon_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TPS = 8;
  localparam int MIN = 60 * TPS;
  logic            clk = 1'b0;
  logic            srst = 1'b1;
  logic [7:0]      addr = 8'h00;
  logic [31:0]     wdata = 32'h0;
  logic            we = 1'b0;
  logic            re = 1'b0;
  logic [31:0]     rdata_q;
  logic [NCAT-1:0] alarm_q;
  logic            unavailable_q;
  line_ev_s        line_ev;
  logic [31:0]     v;
  int              failures = 0;
  int              total_checks = 0;

  line_error_perf_monitor #(.TICKS_PER_SEC(TPS)) dut (.clk(clk),
    .srst(srst), .line_ev(line_ev), .addr(addr), .wdata(wdata),
    .we(we), .re(re), .rdata_q(rdata_q), .alarm_q(alarm_q),
    .unavailable_q(unavailable_q));
  line_framer_model fm (.clk(clk), .line_ev(line_ev));

  initial begin
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : stop_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    we <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    re <= 1'b0;
    @(posedge clk);
    d = rdata_q;
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    rd(a, d);
    check(d, e);
  endtask : rdc

  ////////////////////////////////////////////////////////////////////
  task automatic t_reset_values;
    rdc(8'h00, 32'h2D);
    rdc(8'h01, 32'h0);
    rdc(8'h02, 32'h5);
    rdc(8'h03, 32'h0);
    rdc(8'h04, 32'h0);
    rdc(8'h05, 32'h0);
    rdc(8'h06, 32'h5);
    rdc(8'h07, 32'h5);
    rdc(8'h08, 32'h0);
    rdc(8'h09, 32'h0);
    rdc(8'h0A, 32'h0);
    rdc(8'h0B, 32'h0);
    rdc(8'h50, 32'h1E);
    rdc(8'h0C, 32'h0);
    rdc(8'h60, 32'h0);
    rdc(8'h51, 32'h0);
    check({20'h0, alarm_q}, 32'h0);
  endtask : t_reset_values

  task automatic t_thresholds;
    wr(8'h02, 32'h385);
    rdc(8'h02, 32'h384);
    wr(8'h02, 32'h0);
    rdc(8'h02, 32'h0);
    wr(8'h02, 32'h5);
    tick(1);
    wr(8'h50, 32'hFFFF);
    rdc(8'h50, 32'h384);
    wr(8'h50, 32'h1E);
    tick(1);
    wr(8'h20, 32'h7);
    rdc(8'h20, 32'h0);
  endtask : t_thresholds

  task automatic t_classify;
    fm.pulse(line_ev_s'(8'h80), 1);
    // Poll until the second closes, to place events mid-second
    for (int i = 0; i < 4 * TPS && v !== 32'h1; i++) begin
      rd(8'h20, v);
    end
    check(v, 32'h1);
    tick(1);
    fm.pulse(line_ev_s'(8'h5F), 2);
    tick(TPS - 2);
    fm.pulse(line_ev_s'(8'h40), 1);
    tick(3 * TPS);
    rdc(8'h20, 32'h1);
    rdc(8'h21, 32'h1);
    rdc(8'h25, 32'h2);
    rdc(8'h24, 32'h1);
    rdc(8'h2A, 32'h1);
    rdc(8'h28, 32'h1);
    rdc(8'h29, 32'h1);
    rdc(8'h27, 32'h1);
    rdc(8'h22, 32'h0);
  endtask : t_classify

  task automatic t_severe;
    fm.set_hold(line_ev_s'(8'h20));
    tick(12 * TPS);
    fm.set_hold(line_ev_s'(8'h00));
    tick(2 * TPS);
    rdc(8'h53, 32'h1);
    check({31'h0, unavailable_q}, 32'h1);
    rdc(8'h2B, 32'h1);
    tick(MIN + 2 * TPS);
    check({31'h0, unavailable_q}, 32'h0);
    rdc(8'h10, 32'h1);
    rd(8'h12, v);
    check({31'h0, v >= 32'h5}, 32'h1);
    rd(8'h52, v);
    check({31'h0, v[2]}, 32'h1);
    check({31'h0, v[3]}, 32'h0);
    check({31'h0, v[10]}, 32'h0);
  endtask : t_severe

  task automatic t_clear;
    wr(8'h51, 32'h1);
    tick(2);
    check({20'h0, alarm_q}, 32'h0);
    rdc(8'h12, 32'h0);
    rdc(8'h22, 32'h0);
  endtask : t_clear

  task automatic t_release(input logic [31:0] t, input logic e);
    wr(8'h00, 32'h1);
    tick(1);
    wr(8'h50, t);
    fm.pulse(line_ev_s'(8'h80), 1);
    tick(MIN + 2 * TPS);
    check({31'h0, alarm_q[0]}, 32'h1);
    tick(16 * MIN);
    rdc(8'h10, 32'h0);
    check({31'h0, alarm_q[0]}, {31'h0, e});
    wr(8'h51, 32'h1);
    tick(1);
  endtask : t_release

  task automatic t_history_reset;
    rd(8'h30, v);
    check({31'h0, v != 32'h0}, 32'h1);
    srst <= 1'b1;
    tick(3);
    srst <= 1'b0;
    tick(1);
    rdc(8'h30, 32'h0);
    rdc(8'h00, 32'h2D);
  endtask : t_history_reset

  ////////////////////////////////////////////////////////////////////
  initial begin
    tick(20);
    srst <= 1'b0;
    tick(1);
    t_reset_values;
    t_thresholds;
    t_classify;
    t_severe;
    t_clear;
    t_release(32'h2, 1'b0);
    t_release(32'h0, 1'b1);
    t_history_reset;
    stop_test;
  end

  initial begin
    tick(40000);
    failures++;
    stop_test;
  end
endmodule : line_error_perf_monitor_test
`default_nettype wire
